// >>> gain_regs_pkg.sv
/*
 * shared constants and carrier types for the gain word and readback block.
 * assumes a single system clock; the serial link and gain pins are
 * asynchronous to it and are synchronised inside the block.
 */
package gain_regs_pkg;

    // ************************************************************
    // serial word layout
    // ************************************************************
    localparam int          WORD_W         = 32;
    localparam int          REG_SEL_LSB    = 0;
    localparam int          REG_SEL_W      = 3;
    localparam int          BANK_SEL_LSB   = 3;
    localparam int          BANK_SEL_W     = 2;
    localparam int          ID_LSB         = 5;
    localparam int          ID_W           = 2;
    localparam int          UNUSED_LSB     = 7;
    localparam int          UNUSED_W       = 9;
    localparam int          QDAC_LSB       = 16;
    localparam int          IDAC_LSB       = 24;
    localparam int          DAC_W          = 8;
    localparam int          RB_SEL_LSB     = 28;

    // ************************************************************
    // register addresses (register select plus bank select)
    // ************************************************************
    localparam logic [2:0]  REG_READBACK   = 3'h0;
    localparam logic [2:0]  REG_GAIN_SETUP = 3'h1;
    localparam logic [2:0]  REG_TRIM_SETUP = 3'h5;
    localparam logic [1:0]  BANK_MAIN      = 2'h1;

    // ************************************************************
    // gain setup register fields
    // ************************************************************
    localparam int          GAIN_LSB       = 12;
    localparam int          GAIN_W         = 5;
    localparam int          GAIN_MULT_BIT  = 28;
    localparam logic [4:0]  GAIN_MAX       = 5'h18;
    localparam logic [4:0]  GAIN_RST       = 5'h00;
    localparam logic        GAIN_MULT_RST  = 1'b0;

    // ************************************************************
    // trim setup register fields
    // ************************************************************
    localparam int          TRIM_LSB       = 5;
    localparam int          TRIM_W         = 12;
    localparam logic [11:0] TRIM_RST       = 12'h555;

    // ************************************************************
    // readback reset values
    // ************************************************************
    localparam logic [7:0]  DAC_RST        = 8'h80;
    localparam logic [2:0]  RB_SEL_RST     = 3'h0;
    localparam logic [1:0]  RB_BANK_RST    = 2'h1;
    // version identity, value arbitrary
    localparam logic [1:0]  VERSION_ID     = 2'h2;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic       latch;
        logic       data;
        logic       clk;
    } ser_pins_t;

    typedef struct packed {
        logic [2:0] code;
        ser_pins_t  ser;
    } pin_bundle_t;

    typedef struct packed {
        logic [7:0] inphase;
        logic [7:0] quad;
    } dac_pair_t;

endpackage

// >>> pin_sync.sv
/*
 * two flip-flop synchroniser for a bundle of asynchronous pins.
 * assumes each bit is an independent level; multi-bit codes may be
 * seen torn for one cycle, which the reader must tolerate.
 */
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 6
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // ************************************************************
    // per-bit two-stage capture
    // ************************************************************
    // first stage feeds only the second stage
    always_comb begin
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule

// >>> gain_word_and_readback_regs.sv
/*
 * serial-port register bank for baseband gain control and calibration
 * readback: receives 32-bit words lsb first, holds the gain and trim
 * setup fields, merges the fast gain-reduction pins into the effective
 * gain word and shifts out the read-only calibration readback word.
 * assumes serial clock, data, latch and gain pins are asynchronous and
 * much slower than sys_clk; calibration logic on sys_clk supplies dac codes.
 */
`timescale 1ns/100ps
module gain_word_and_readback_regs (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     ser_clk,
    input  wire logic                     ser_data,
    input  wire logic                     ser_latch,
    input  wire logic                     fast_reduce_pin_0,
    input  wire logic                     fast_reduce_pin_1,
    input  wire logic                     fast_reduce_pin_2,
    input  wire logic                     dac_load,
    input  wire gain_regs_pkg::dac_pair_t dac_codes,
    output logic                          readback_out,
    output logic                          readback_oe,
    output logic [4:0]                    baseband_level_word,
    output logic [31:0]                   block_trim_setup,
    output logic                          gain_mult_double,
    output gain_regs_pkg::dac_pair_t      offset_dac_codes
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        gain_regs_pkg::ser_pins_t ser_prev;
        logic [31:0]              shift_in;
        logic [31:0]              shift_out;
        logic                     rb_armed;
        logic [2:0]               rb_sel;
        logic [1:0]               rb_bank;
        logic [4:0]               gain_set;
        logic                     gain_mult;
        logic [11:0]              trim;
        gain_regs_pkg::dac_pair_t dac;
        logic [4:0]               level;
    } regs_state_t;

    regs_state_t                st_r;
    regs_state_t                st_nxt;
    gain_regs_pkg::pin_bundle_t pins_async;
    gain_regs_pkg::pin_bundle_t pins_sync;

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    // serial link and gain pins all cross from outside the sys_clk domain
    assign pins_async.code      = {fast_reduce_pin_2, fast_reduce_pin_1, fast_reduce_pin_0};
    assign pins_async.ser.clk   = ser_clk;
    assign pins_async.ser.data  = ser_data;
    assign pins_async.ser.latch = ser_latch;

    pin_sync #(
        .W        ($bits(gain_regs_pkg::pin_bundle_t))
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // ************************************************************
    // readback word assembly
    // ************************************************************
    // the word is built only from held state; of the written fields only the readback select reaches it
    function automatic logic [31:0] readback_word(input regs_state_t s);
        logic [31:0] w;
        w = '0;
        w[gain_regs_pkg::REG_SEL_LSB +: gain_regs_pkg::REG_SEL_W]   = s.rb_sel;
        w[gain_regs_pkg::BANK_SEL_LSB +: gain_regs_pkg::BANK_SEL_W] = s.rb_bank;
        w[gain_regs_pkg::ID_LSB +: gain_regs_pkg::ID_W]   = gain_regs_pkg::VERSION_ID;
        w[gain_regs_pkg::QDAC_LSB +: gain_regs_pkg::DAC_W] = s.dac.quad;
        w[gain_regs_pkg::IDAC_LSB +: gain_regs_pkg::DAC_W] = s.dac.inphase;
        return w;
    endfunction

    // ************************************************************
    // effective gain computation
    // ************************************************************
    // clamp first so an out-of-range setting never exceeds full scale
    function automatic logic [4:0] effective_gain(input logic [4:0] set,
                                                  input logic       dbl,
                                                  input logic [2:0] code);
        logic [4:0] clamped;
        logic [4:0] reduce;
        clamped = (set > gain_regs_pkg::GAIN_MAX) ? gain_regs_pkg::GAIN_MAX : set;
        reduce  = dbl ? {1'b0, code, 1'b0} : {2'b00, code};
        if (clamped >= reduce) begin
            effective_gain = clamped - reduce;
        end else begin
            effective_gain = 5'h00;
        end
    endfunction

    // ************************************************************
    // next-state logic
    // ************************************************************
    logic        clk_rise;
    logic        clk_fall;
    logic        latch_rise;
    logic [31:0] word_in;
    logic [2:0]  w_reg;
    logic [1:0]  w_bank;

    always_comb begin
        st_nxt     = st_r;
        clk_rise   = pins_sync.ser.clk & ~st_r.ser_prev.clk;
        clk_fall   = ~pins_sync.ser.clk & st_r.ser_prev.clk;
        latch_rise = pins_sync.ser.latch & ~st_r.ser_prev.latch;
        word_in    = st_r.shift_in;
        w_reg      = word_in[gain_regs_pkg::REG_SEL_LSB +: gain_regs_pkg::REG_SEL_W];
        w_bank     = word_in[gain_regs_pkg::BANK_SEL_LSB +: gain_regs_pkg::BANK_SEL_W];

        st_nxt.ser_prev = pins_sync.ser;

        // lsb arrives first, so new bits enter at the top
        if (clk_rise) begin
            st_nxt.shift_in = {pins_sync.ser.data, st_r.shift_in[31:1]};
        end

        // present the next readback bit after each falling edge
        if (clk_fall && st_r.rb_armed) begin
            st_nxt.shift_out = {1'b0, st_r.shift_out[31:1]};
        end

        // calibration logic owns the dac codes; the serial port cannot write them
        if (dac_load) begin
            st_nxt.dac = dac_codes;
        end

        // word decode on latch; any transfer but a readback command ends an armed readback
        if (latch_rise) begin
            st_nxt.rb_armed = 1'b0;
            if (w_bank == gain_regs_pkg::BANK_MAIN) begin
                case (w_reg)
                    gain_regs_pkg::REG_GAIN_SETUP: begin
                        st_nxt.gain_set  = word_in[gain_regs_pkg::GAIN_LSB +:
                                                   gain_regs_pkg::GAIN_W];
                        st_nxt.gain_mult = word_in[gain_regs_pkg::GAIN_MULT_BIT];
                    end
                    gain_regs_pkg::REG_TRIM_SETUP: begin
                        st_nxt.trim = word_in[gain_regs_pkg::TRIM_LSB +:
                                              gain_regs_pkg::TRIM_W];
                    end
                    gain_regs_pkg::REG_READBACK: begin
                        // command word names the register; data fields stay untouched
                        st_nxt.rb_sel   = word_in[gain_regs_pkg::RB_SEL_LSB +:
                                                  gain_regs_pkg::REG_SEL_W];
                        st_nxt.rb_bank  = gain_regs_pkg::BANK_MAIN;
                        st_nxt.rb_armed = 1'b1;
                    end
                    default: begin
                        st_nxt.rb_armed = 1'b0;
                    end
                endcase
            end
        end

        // snapshot the readback word when the command is accepted
        if (st_nxt.rb_armed && !st_r.rb_armed) begin
            st_nxt.shift_out = readback_word(st_nxt);
        end

        // pins act every cycle without any serial traffic
        st_nxt.level = effective_gain(st_r.gain_set, st_r.gain_mult, pins_sync.code);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r.ser_prev    <= '0;
            st_r.shift_in    <= '0;
            st_r.shift_out   <= '0;
            st_r.rb_armed    <= 1'b0;
            st_r.rb_sel      <= gain_regs_pkg::RB_SEL_RST;
            st_r.rb_bank     <= gain_regs_pkg::RB_BANK_RST;
            st_r.gain_set    <= gain_regs_pkg::GAIN_RST;
            st_r.gain_mult   <= gain_regs_pkg::GAIN_MULT_RST;
            st_r.trim        <= gain_regs_pkg::TRIM_RST;
            st_r.dac.quad    <= gain_regs_pkg::DAC_RST;
            st_r.dac.inphase <= gain_regs_pkg::DAC_RST;
            st_r.level       <= gain_regs_pkg::GAIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs, all taken straight from state flops or constants
    // ************************************************************
    assign readback_out        = st_r.shift_out[0];
    assign readback_oe         = st_r.rb_armed;
    assign baseband_level_word = st_r.level;
    assign gain_mult_double    = st_r.gain_mult;
    assign offset_dac_codes    = st_r.dac;
    // upper trim bits are held at zero by construction; low bits echo the address
    assign block_trim_setup    = {15'h0000, st_r.trim,
                                  gain_regs_pkg::BANK_MAIN, gain_regs_pkg::REG_TRIM_SETUP};

endmodule

// >>> gain_regs_asserts.sv
/*
 * checker for the gain word and readback block, bound to its ports.
 * assumes pins change far slower than sys_clk, as the host model does.
 */
`timescale 1ns/100ps
module gain_regs_asserts (
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic                     ser_clk,
    input wire logic                     ser_latch,
    input wire logic                     fast_reduce_pin_0,
    input wire logic                     fast_reduce_pin_1,
    input wire logic                     fast_reduce_pin_2,
    input wire logic                     dac_load,
    input wire gain_regs_pkg::dac_pair_t dac_codes,
    input wire logic                     readback_out,
    input wire logic                     readback_oe,
    input wire logic [4:0]               baseband_level_word,
    input wire logic [31:0]              block_trim_setup,
    input wire logic                     gain_mult_double,
    input wire gain_regs_pkg::dac_pair_t offset_dac_codes
);
    // ****************
    // quiet-time count
    // ****************
    logic [3:0] quiet_cnt_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles since any gain pin or the latch moved; sync plus decode settle well inside 6
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quiet_cnt_r <= 4'h0;
        end else if ($changed({fast_reduce_pin_2, fast_reduce_pin_1, fast_reduce_pin_0,
                               ser_latch})) begin
            quiet_cnt_r <= 4'h0;
        end else if (quiet_cnt_r != 4'hf) begin
            quiet_cnt_r <= quiet_cnt_r + 4'h1;
        end
    end
    chk_level_range: assert property (baseband_level_word <= 5'h18)
        else $error("level word above full range");
    chk_level_quiet: assert property (quiet_cnt_r >= 4'h6 |-> $stable(baseband_level_word))
        else $error("level word moved with quiet inputs");
    chk_trim_unused: assert property (block_trim_setup[31:17] == 15'h0)
        else $error("trim upper bits not zero");
    chk_dac_load: assert property (dac_load |=> offset_dac_codes == $past(dac_codes))
        else $error("dac codes not taken");
    chk_dac_hold: assert property (!dac_load |=> $stable(offset_dac_codes))
        else $error("dac codes moved without load");
    chk_dac_reset: assert property ($past(rst) |-> offset_dac_codes == 16'h8080)
        else $error("dac codes not half scale after reset");
    chk_oe_drop: assert property ($rose(ser_latch) && readback_oe |-> ##[1:8] !readback_oe)
        else $error("readback drive held past latch");
    chk_rb_steady: assert property ((readback_oe && ser_clk) [*5] |-> $stable(readback_out))
        else $error("readback bit moved while clock high");
    chk_mult_latch: assert property ($changed(gain_mult_double) |->
        $past(ser_latch, 3) || $past(ser_latch, 4) || $past(ser_latch, 5))
        else $error("multiplier moved without latch");
    cover property ($rose(readback_oe));
    cover property (gain_mult_double && baseband_level_word == 5'h00);
    cover property (dac_load);
endmodule

// >>> serial_host_model.sv
/*
 * host controller model: shifts 32-bit words on the three-wire port
 * and sets the fast gain pins. assumes sys_clk at 100 MHz.
 */
`timescale 1ns/100ps
module serial_host_model (
    input  wire logic                  sys_clk,
    input  wire logic                  readback_out,
    input  wire logic                  readback_oe,
    output gain_regs_pkg::pin_bundle_t pins
);
    // ********************
    // serial frame driver
    // ********************
    initial begin
        pins = '0;
    end
    // half of a 160 ns link period
    task automatic half_bit();
        repeat (8) @(posedge sys_clk);
    endtask
    // clock stays low between frames; data shows the inverse once released
    task automatic send_word(input logic [31:0] w, output logic [31:0] rb);
        for (int i = 0; i < 32; i++) begin
            pins.ser.data <= w[i];
            half_bit();
            pins.ser.clk <= 1'b1;
            // a released readback line shows the inverse, so a dropped enable is seen
            rb[i] = readback_oe ? readback_out : ~readback_out;
            half_bit();
            pins.ser.clk <= 1'b0;
        end
        half_bit();
        pins.ser.latch <= 1'b1;
        half_bit();
        pins.ser.latch <= 1'b0;
        pins.ser.data <= ~w[31];
        half_bit();
    endtask
    task automatic set_code(input logic [2:0] c);
        @(posedge sys_clk);
        pins.code <= c;
    endtask
endmodule

// >>> tb.sv
/*
 * testbench for the gain word and readback block.
 * assumes the host model drives all serial and gain pins.
 */
`timescale 1ns/100ps
module tb;
    // *************
    // bench signals
    // *************
    logic                       sys_clk;
    logic                       rst;
    logic                       dac_load;
    gain_regs_pkg::dac_pair_t   dac_codes;
    gain_regs_pkg::pin_bundle_t pins;
    logic                       readback_out;
    logic                       readback_oe;
    logic [4:0]                 baseband_level_word;
    logic [31:0]                block_trim_setup;
    logic                       gain_mult_double;
    gain_regs_pkg::dac_pair_t   offset_dac_codes;
    logic [31:0]                rb;
    int                         err_total;
    int                         samples_checked;
    int                         cycle_cnt;
    gain_word_and_readback_regs u_gain_word_and_readback_regs (.sys_clk(sys_clk), .rst(rst),
        .ser_clk(pins.ser.clk), .ser_data(pins.ser.data), .ser_latch(pins.ser.latch),
        .fast_reduce_pin_0(pins.code[0]), .fast_reduce_pin_1(pins.code[1]),
        .fast_reduce_pin_2(pins.code[2]), .dac_load(dac_load), .dac_codes(dac_codes),
        .readback_out(readback_out), .readback_oe(readback_oe),
        .baseband_level_word(baseband_level_word), .block_trim_setup(block_trim_setup),
        .gain_mult_double(gain_mult_double), .offset_dac_codes(offset_dac_codes));
    serial_host_model u_serial_host_model (.sys_clk(sys_clk), .readback_out(readback_out),
        .readback_oe(readback_oe), .pins(pins));
    task automatic test_done();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // saturating reference for the effective level
    function automatic logic [4:0] exp_level(logic [4:0] g, logic m, logic [2:0] c);
        int lim;
        int red;
        lim = (g > 5'h18) ? 24 : int'(g);
        red = m ? 2 * int'(c) : int'(c);
        return (lim > red) ? 5'(lim - red) : 5'h00;
    endfunction
    // command, then a dummy frame that carries the word back
    task automatic readback(input logic [2:0] sel, input logic [7:0] q, input logic [7:0] i);
        logic [31:0] dummy;
        u_serial_host_model.send_word({1'b0, sel, 23'h0, 5'h08}, dummy);
        chk("oe_armed", readback_oe, 1);
        u_serial_host_model.send_word(32'h0, rb);
        chk("oe_dropped", readback_oe, 0);
        chk("rb_sel", rb[2:0], sel);
        chk("rb_bank", rb[4:3], gain_regs_pkg::BANK_MAIN);
        chk("rb_id", rb[6:5], gain_regs_pkg::VERSION_ID);
        chk("rb_unused", rb[15:7], 0);
        chk("rb_quad", rb[23:16], q);
        chk("rb_inphase", rb[31:24], i);
    endtask
    logic [8:0] gain_case [7] = '{{5'h11, 1'b0, 3'h0}, {5'h18, 1'b0, 3'h5}, {5'h11, 1'b1, 3'h7},
        {5'h05, 1'b1, 3'h7}, {5'h1f, 1'b0, 3'h0}, {5'h1f, 1'b1, 3'h3}, {5'h03, 1'b0, 3'h4}};
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard, well above the roughly 8200 cycles of the sequence
    always @(posedge sys_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 40000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        dac_load = 1'b0;
        dac_codes = '0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("trim_reset", block_trim_setup, 32'h0000aaad);
        chk("dac_reset", offset_dac_codes, 16'h8080);
        readback(3'h5, 8'h80, 8'h80);
        // gain and multiplier written, then pins alone change the level
        for (int k = 0; k < 7; k++) begin
            u_serial_host_model.send_word({3'h0, gain_case[k][3], 11'h0, gain_case[k][8:4],
                7'h0, 5'h09}, rb);
            u_serial_host_model.set_code(gain_case[k][2:0]);
            repeat (8) @(posedge sys_clk);
            chk("mult", gain_mult_double, gain_case[k][3]);
            chk("level", baseband_level_word, exp_level(gain_case[k][8:4], gain_case[k][3],
                gain_case[k][2:0]));
        end
        // nominal 17 at double step, sweep every pin code
        u_serial_host_model.send_word({3'h0, 1'b1, 11'h0, 5'h11, 7'h0, 5'h09}, rb);
        for (int c = 0; c < 8; c++) begin
            u_serial_host_model.set_code(3'(c));
            repeat (8) @(posedge sys_clk);
            chk("sweep", baseband_level_word, exp_level(5'h11, 1'b1, 3'(c)));
        end
        // a foreign bank and an unbuilt register must both be ignored
        u_serial_host_model.send_word({3'h0, 1'b0, 11'h0, 5'h05, 7'h0, 5'h11}, rb);
        chk("bank_ignored", baseband_level_word, exp_level(5'h11, 1'b1, 3'h7));
        u_serial_host_model.send_word({3'h0, 1'b0, 11'h0, 5'h05, 7'h0, 5'h0a}, rb);
        chk("reg_ignored", gain_mult_double, 1'b1);
        u_serial_host_model.send_word({15'h7fff, 12'h3c6, 5'h0d}, rb);
        chk("trim_write", block_trim_setup, {15'h0, 12'h3c6, 5'h0d});
        @(posedge sys_clk);
        dac_load <= 1'b1;
        dac_codes <= {8'hc5, 8'h3c};
        @(posedge sys_clk);
        dac_load <= 1'b0;
        @(posedge sys_clk);
        chk("dac_load", offset_dac_codes, 16'hc53c);
        readback(3'h1, 8'h3c, 8'hc5);
        chk("dac_kept", offset_dac_codes, 16'hc53c);
        // reset in mid-run restores every default
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("level_rst", baseband_level_word, 5'h00);
        chk("mult_rst", gain_mult_double, gain_regs_pkg::GAIN_MULT_RST);
        chk("oe_rst", readback_oe, 1'b0);
        chk("dac_rst", offset_dac_codes, 16'h8080);
        test_done();
    end
endmodule
bind gain_word_and_readback_regs gain_regs_asserts u_gain_regs_asserts (.sys_clk(sys_clk),
    .rst(rst), .ser_clk(ser_clk), .ser_latch(ser_latch),
    .fast_reduce_pin_0(fast_reduce_pin_0), .fast_reduce_pin_1(fast_reduce_pin_1),
    .fast_reduce_pin_2(fast_reduce_pin_2), .dac_load(dac_load), .dac_codes(dac_codes),
    .readback_out(readback_out), .readback_oe(readback_oe),
    .baseband_level_word(baseband_level_word), .block_trim_setup(block_trim_setup),
    .gain_mult_double(gain_mult_double), .offset_dac_codes(offset_dac_codes));
